/* File: rtl/pafo_regs.vh */
// register offsets, field positions and reset values for the port override block
`ifndef PAFO_REGS_VH
`define PAFO_REGS_VH
`define PAFO_IO_LAST 8'h3F
`define PAFO_DATA_OFS 8'h20
`define PAFO_EXT_BASE 8'h60
`define PAFO_DIR_A_OFS 8'h1A
`define PAFO_OUT_A_OFS 8'h1B
`define PAFO_SFIO_OFS 8'h20
`define PAFO_SFIO_DATA_ADDR 8'h40
`define PAFO_PUD_BIT 2
`define PAFO_DIR_A_RST 8'h00
`define PAFO_OUT_A_RST 8'h00
`define PAFO_SFIO_RST 8'h00
`define PAFO_TDI_BIT 7
`define PAFO_TDO_BIT 6
`define PAFO_TMS_BIT 5
`define PAFO_TCK_BIT 4
`define PAFO_OSC_IN_BIT 4
`define PAFO_OSC_OUT_BIT 3
`define PAFO_ALE_BIT 2
`define PAFO_RD_BIT 1
`define PAFO_WR_BIT 0
`endif

/* File: rtl/pafo_port_override.v */
// port alternate function override logic for the analog and strobe ports
`timescale 1ns/10ps
`include "pafo_regs.vh"
module pafo_port_override #(
  parameter W = 8
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire io_wr,
  input wire io_rd,
  input wire data_wr,
  input wire data_rd,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  input wire test_port_enable,
  input wire tap_shift_ir,
  input wire tap_shift_dr,
  input wire tap_tdo,
  input wire async_timer_clock_select,
  input wire ext_memory_enable,
  input wire legacy_mode,
  input wire mem_ale,
  input wire mem_rd_n,
  input wire mem_wr_n,
  input wire [W-1:0] port_f_output_bit,
  input wire [W-1:0] port_f_direction_bit,
  input wire [W-1:0] port_g_output_bit,
  input wire [W-1:0] port_g_direction_bit,
  output reg [W-1:0] port_a_out,
  output reg [W-1:0] port_a_oe,
  output reg [W-1:0] port_a_pullup,
  output reg [W-1:0] port_f_out,
  output reg [W-1:0] port_f_oe,
  output reg [W-1:0] port_f_pullup,
  output reg [W-1:0] port_f_input_disable,
  output reg [W-1:0] port_g_out,
  output reg [W-1:0] port_g_oe,
  output reg [W-1:0] port_g_pullup,
  output reg [W-1:0] port_g_input_disable
);

// ----------------------------------------------------------------
// register file
// ----------------------------------------------------------------
reg [7:0] dir_a_reg;
reg [7:0] out_a_reg;
reg [7:0] sfio_reg;
reg [7:0] rdata_next;
reg [7:0] io_ofs;
reg acc_wr;
reg acc_rd;
reg hit_ok;

// io instructions see 0x00-0x3F; data accesses add 0x20 and stop
// at 0x5F; nothing decodes from 0x60 up
always @* begin
  acc_wr = 1'b0;
  acc_rd = 1'b0;
  io_ofs = 8'h00;
  hit_ok = 1'b0;
  if ((io_wr || io_rd) && addr <= `PAFO_IO_LAST) begin
    io_ofs = addr;
    hit_ok = 1'b1;
    acc_wr = io_wr;
    acc_rd = io_rd;
  end else if ((data_wr || data_rd) && addr >= `PAFO_DATA_OFS &&
               addr < `PAFO_EXT_BASE) begin
    io_ofs = addr - `PAFO_DATA_OFS;
    hit_ok = 1'b1;
    acc_wr = data_wr;
    acc_rd = data_rd;
  end
end

always @* begin
  rdata_next = 8'h00;
  if (acc_rd && hit_ok) begin
    case (io_ofs)
      `PAFO_DIR_A_OFS: rdata_next = dir_a_reg;
      `PAFO_OUT_A_OFS: rdata_next = out_a_reg;
      `PAFO_SFIO_OFS: rdata_next = sfio_reg;
      default: rdata_next = 8'h00;
    endcase
  end
end

always @(posedge ref_clk or posedge sys_rst) begin
  if (sys_rst) begin
    rdata <= 8'h00;
  end else begin
    rdata <= rdata_next;
  end
end

always @(posedge ref_clk or posedge sys_rst) begin
  if (sys_rst) begin
    dir_a_reg <= `PAFO_DIR_A_RST;
  end else if (acc_wr && io_ofs == `PAFO_DIR_A_OFS) begin
    dir_a_reg <= wdata;
  end
end

always @(posedge ref_clk or posedge sys_rst) begin
  if (sys_rst) begin
    out_a_reg <= `PAFO_OUT_A_RST;
  end else if (acc_wr && io_ofs == `PAFO_OUT_A_OFS) begin
    out_a_reg <= wdata;
  end
end

always @(posedge ref_clk or posedge sys_rst) begin
  if (sys_rst) begin
    sfio_reg <= `PAFO_SFIO_RST;
  end else if (acc_wr && io_ofs == `PAFO_SFIO_OFS) begin
    sfio_reg <= wdata;
  end
end

wire pullup_disable = sfio_reg[`PAFO_PUD_BIT];

// ----------------------------------------------------------------
// override generation
// ----------------------------------------------------------------
reg [W-1:0] f_pullup_override_enable;
reg [W-1:0] f_pullup_override_value;
reg [W-1:0] f_direction_override_enable;
reg [W-1:0] f_direction_override_value;
reg [W-1:0] f_port_value_override_enable;
reg [W-1:0] f_port_value_override_value;
reg [W-1:0] f_input_disable_override_enable;
reg [W-1:0] g_pullup_override_enable;
reg [W-1:0] g_pullup_override_value;
reg [W-1:0] g_direction_override_enable;
reg [W-1:0] g_direction_override_value;
reg [W-1:0] g_port_value_override_enable;
reg [W-1:0] g_port_value_override_value;
reg [W-1:0] g_input_disable_override_enable;
wire jt = test_port_enable;
wire osc = async_timer_clock_select;
// legacy mode forces the strobe functions regardless of software
wire mem = ext_memory_enable | legacy_mode;

always @* begin
  // lower analog pins keep every enable and value at zero
  f_pullup_override_enable = {W{1'b0}};
  f_pullup_override_value = {W{1'b0}};
  f_direction_override_enable = {W{1'b0}};
  f_direction_override_value = {W{1'b0}};
  f_port_value_override_enable = {W{1'b0}};
  f_port_value_override_value = {W{1'b0}};
  f_input_disable_override_enable = {W{1'b0}};
  // test pins: tck, tms, tdi and tdo withheld from io, scan runs on tck
  f_pullup_override_enable[`PAFO_TCK_BIT] = jt;
  f_pullup_override_value[`PAFO_TCK_BIT] = 1'b1;
  f_direction_override_enable[`PAFO_TCK_BIT] = jt;
  f_input_disable_override_enable[`PAFO_TCK_BIT] = jt;
  f_pullup_override_enable[`PAFO_TMS_BIT] = jt;
  f_pullup_override_value[`PAFO_TMS_BIT] = 1'b1;
  f_direction_override_enable[`PAFO_TMS_BIT] = jt;
  f_input_disable_override_enable[`PAFO_TMS_BIT] = jt;
  f_pullup_override_enable[`PAFO_TDI_BIT] = jt;
  f_pullup_override_value[`PAFO_TDI_BIT] = 1'b1;
  f_direction_override_enable[`PAFO_TDI_BIT] = jt;
  f_input_disable_override_enable[`PAFO_TDI_BIT] = jt;
  f_pullup_override_enable[`PAFO_TDO_BIT] = jt;
  f_direction_override_enable[`PAFO_TDO_BIT] = jt;
  f_input_disable_override_enable[`PAFO_TDO_BIT] = jt;
  f_direction_override_value[`PAFO_TDO_BIT] = tap_shift_ir | tap_shift_dr;
  f_port_value_override_enable[`PAFO_TDO_BIT] = jt;
  f_port_value_override_value[`PAFO_TDO_BIT] = tap_tdo;

  g_pullup_override_enable = {W{1'b0}};
  g_pullup_override_value = {W{1'b0}};
  g_direction_override_enable = {W{1'b0}};
  g_direction_override_value = {W{1'b0}};
  g_port_value_override_enable = {W{1'b0}};
  g_port_value_override_value = {W{1'b0}};
  g_input_disable_override_enable = {W{1'b0}};
  g_pullup_override_enable[`PAFO_OSC_IN_BIT] = osc;
  g_direction_override_enable[`PAFO_OSC_IN_BIT] = osc;
  g_input_disable_override_enable[`PAFO_OSC_IN_BIT] = osc;
  g_pullup_override_enable[`PAFO_OSC_OUT_BIT] = osc;
  g_direction_override_enable[`PAFO_OSC_OUT_BIT] = osc;
  g_input_disable_override_enable[`PAFO_OSC_OUT_BIT] = osc;
  g_pullup_override_enable[`PAFO_ALE_BIT] = mem;
  g_direction_override_enable[`PAFO_ALE_BIT] = mem;
  g_direction_override_value[`PAFO_ALE_BIT] = 1'b1;
  g_port_value_override_enable[`PAFO_ALE_BIT] = mem;
  g_port_value_override_value[`PAFO_ALE_BIT] = mem_ale;
  g_pullup_override_enable[`PAFO_RD_BIT] = mem;
  g_direction_override_enable[`PAFO_RD_BIT] = mem;
  g_direction_override_value[`PAFO_RD_BIT] = 1'b1;
  g_port_value_override_enable[`PAFO_RD_BIT] = mem;
  g_port_value_override_value[`PAFO_RD_BIT] = mem_rd_n;
  g_pullup_override_enable[`PAFO_WR_BIT] = mem;
  g_direction_override_enable[`PAFO_WR_BIT] = mem;
  g_direction_override_value[`PAFO_WR_BIT] = 1'b1;
  g_port_value_override_enable[`PAFO_WR_BIT] = mem;
  g_port_value_override_value[`PAFO_WR_BIT] = mem_wr_n;
end

// ----------------------------------------------------------------
// pin resolution
// ----------------------------------------------------------------
// normal pull-up: input with output bit set and pull-ups not disabled
wire [W-1:0] a_pu = ~dir_a_reg & out_a_reg & {W{~pullup_disable}};
wire [W-1:0] f_pu = ~port_f_direction_bit & port_f_output_bit & {W{~pullup_disable}};
wire [W-1:0] g_pu = ~port_g_direction_bit & port_g_output_bit & {W{~pullup_disable}};

wire [W-1:0] f_pu_n = (f_pullup_override_enable & f_pullup_override_value) | (~f_pullup_override_enable & f_pu);
wire [W-1:0] f_oe_n = (f_direction_override_enable & f_direction_override_value) |
                      (~f_direction_override_enable & port_f_direction_bit);
wire [W-1:0] f_out_n = (f_port_value_override_enable & f_port_value_override_value) |
                       (~f_port_value_override_enable & port_f_output_bit);
wire [W-1:0] g_pu_n = (g_pullup_override_enable & g_pullup_override_value) | (~g_pullup_override_enable & g_pu);
wire [W-1:0] g_oe_n = (g_direction_override_enable & g_direction_override_value) |
                      (~g_direction_override_enable & port_g_direction_bit);
wire [W-1:0] g_out_n = (g_port_value_override_enable & g_port_value_override_value) |
                       (~g_port_value_override_enable & port_g_output_bit);

// test pin pullups come from override enable and value, gated by jt
wire [W-1:0] f_pu_rst = f_pullup_override_enable & f_pullup_override_value & {W{jt}};

// ----------------------------------------------------------------
// pin output registers
// ----------------------------------------------------------------
always @(posedge ref_clk or posedge sys_rst) begin
  if (sys_rst) begin
    port_a_out <= {W{1'b0}};
    port_a_oe <= {W{1'b0}};
    port_a_pullup <= {W{1'b0}};
  end else begin
    port_a_out <= out_a_reg;
    port_a_oe <= dir_a_reg;
    port_a_pullup <= a_pu;
  end
end

always @(posedge ref_clk or posedge sys_rst) begin
  if (sys_rst) begin
    port_f_out <= {W{1'b0}};
    port_f_oe <= {W{1'b0}};
    port_f_input_disable <= {W{1'b0}};
  end else begin
    port_f_out <= f_out_n;
    port_f_oe <= f_oe_n;
    port_f_input_disable <= f_input_disable_override_enable;
  end
end

always @(posedge ref_clk or posedge sys_rst) begin
  if (sys_rst) begin
    port_g_out <= {W{1'b0}};
    port_g_oe <= {W{1'b0}};
    port_g_pullup <= {W{1'b0}};
    port_g_input_disable <= {W{1'b0}};
  end else begin
    port_g_out <= g_out_n;
    port_g_oe <= g_oe_n;
    port_g_pullup <= g_pu_n;
    port_g_input_disable <= g_input_disable_override_enable;
  end
end

// ----------------------------------------------------------------
// test pin pullups
// ----------------------------------------------------------------
// no async reset here: the test pin pullups must hold through reset
// while the port stays enabled; reset only masks the other bits
always @(posedge ref_clk) begin
  if (sys_rst) begin
    port_f_pullup <= f_pu_rst;
  end else begin
    port_f_pullup <= f_pu_n | f_pu_rst;
  end
end

endmodule // pafo_port_override

/* File: tb/pafo_port_override_monitor.sv */
// assertion checker for the port override block
`timescale 1ns/10ps
module pafo_port_override_monitor #(parameter W = 8) (
  input wire ref_clk, sys_rst, io_rd, data_rd,
  input wire [7:0] rdata,
  input wire test_port_enable, tap_shift_ir, tap_shift_dr, tap_tdo,
  input wire async_timer_clock_select, ext_memory_enable, legacy_mode,
  input wire mem_ale, mem_rd_n, mem_wr_n,
  input wire [W-1:0] port_f_direction_bit, port_f_out, port_f_oe,
  input wire [W-1:0] port_f_pullup, port_g_out, port_g_oe, port_g_pullup
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire [2:0] strobes = {mem_ale, mem_rd_n, mem_wr_n};
  wire shifting = tap_shift_ir | tap_shift_dr;
  a_tdo_value: assert property (
    test_port_enable |=> port_f_out[6] == $past(tap_tdo)) else $error("tdo");
  a_tdo_drive: assert property (
    test_port_enable |=> port_f_oe[6] == $past(shifting)) else $error("oe6");
  a_test_pullup: assert property (
    test_port_enable |=> port_f_pullup[7:4] == 4'hB) else $error("pull");
  a_test_input: assert property (
    test_port_enable |=> (port_f_oe[7:4] & 4'hB) == 4'h0) else $error("dir");
  a_low_pins: assert property (
    1'b1 |=> port_f_oe[3:0] == $past(port_f_direction_bit[3:0]))
    else $error("low pins");
  a_osc_pins: assert property (
    async_timer_clock_select |=> (port_g_oe[4:3] | port_g_pullup[4:3]) == 2'h0)
    else $error("osc pins");
  a_strobe_pins: assert property (
    ext_memory_enable |=> port_g_oe[2:0] == 3'h7 &&
    port_g_out[2:0] == $past(strobes)) else $error("strobes");
  a_legacy_port: assert property (
    legacy_mode |=> port_g_oe[2:0] == 3'h7) else $error("legacy");
  a_read_idle: assert property (
    !(io_rd || data_rd) |=> rdata == 8'h00) else $error("rdata idle");
  c_shift: cover property (test_port_enable && tap_shift_dr);
  c_osc: cover property (async_timer_clock_select);
  c_strobe: cover property (ext_memory_enable && mem_ale);
endmodule // pafo_port_override_monitor
bind pafo_port_override pafo_port_override_monitor #(.W(W))
  i_pafo_port_override_monitor (.*);

/* File: tb/pafo_far_side.sv */
// far-side model: test port state and memory strobes
`timescale 1ns/10ps
module pafo_far_side (
  input wire ref_clk,
  input wire run,
  output wire tap_shift_ir, tap_shift_dr, tap_tdo,
  output wire mem_ale, mem_rd_n, mem_wr_n
);
  logic [3:0] cnt_reg = 4'h0;
  // a stepping pattern, so a stale pin value cannot pass a check
  always @(posedge ref_clk) cnt_reg <= run ? cnt_reg + 4'h1 : 4'h0;
  assign tap_shift_ir = cnt_reg[3:2] == 2'h1;
  assign tap_shift_dr = cnt_reg[3:2] == 2'h2;
  assign tap_tdo = cnt_reg[0] ^ cnt_reg[2];
  assign mem_ale = cnt_reg[1:0] == 2'h0;
  assign mem_rd_n = !cnt_reg[1];
  assign mem_wr_n = !cnt_reg[0];
endmodule // pafo_far_side

/* File: tb/tb_port_alt_function_override.sv */
// self-checking bench for the port override block
`timescale 1ns/10ps
`include "pafo_regs.vh"
module tb_port_alt_function_override;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic io_wr = 1'b0, io_rd = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
  logic run = 1'b0, pu_off = 1'b0, test_port_enable = 1'b0;
  logic async_timer_clock_select = 1'b0, ext_memory_enable = 1'b0;
  logic legacy_mode = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, port_g_direction_bit = 8'h00;
  logic [7:0] port_f_output_bit = 8'hFF, port_g_output_bit = 8'hFF;
  logic [7:0] port_f_direction_bit = 8'h0C;
  wire [7:0] rdata, port_a_out, port_a_oe, port_a_pullup, port_f_out;
  wire [7:0] port_f_oe, port_f_pullup, port_f_input_disable, port_g_out;
  wire [7:0] port_g_oe, port_g_pullup, port_g_input_disable;
  wire tap_shift_ir, tap_shift_dr, tap_tdo, mem_ale, mem_rd_n, mem_wr_n;
  int num_errors = 0;
  int tests_run = 0;
  pafo_port_override i_pafo_port_override (.*);
  pafo_far_side i_pafo_far_side (.*);
  initial forever #2.5 ref_clk = !ref_clk;
  task automatic stop_test;
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic io, w, input logic [7:0] a, d);
    @(posedge ref_clk);
    {io_wr, data_wr, io_rd, data_rd} <= {io & w, !io & w, io & !w, !io & !w};
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    {io_wr, data_wr, io_rd, data_rd} <= 4'h0;
    #1;
    if (!w) chk(rdata, d);
  endtask
  // pin controls expected one cycle after the inputs seen now
  task automatic pins;
    logic [7:0] ee, ep, ho, he, hp, fi, gi;
    logic eo;
    @(posedge ref_clk);
    #1;
    eo = test_port_enable ? tap_tdo : 1'b1;
    ee = 8'h0C;
    ep = pu_off ? 8'h00 : 8'hF3;
    ho = 8'hFF;
    he = 8'h00;
    hp = pu_off ? 8'h00 : 8'hFF;
    fi = test_port_enable ? 8'hF0 : 8'h00;
    gi = async_timer_clock_select ? 8'h18 : 8'h00;
    if (test_port_enable) begin
      ee[7:4] = {2'h0, tap_shift_ir | tap_shift_dr, 1'b0} << 1;
      ep[7:4] = 4'hB;
    end
    if (async_timer_clock_select) hp[4:3] = 2'h0;
    if (ext_memory_enable | legacy_mode) begin
      ho[2:0] = {mem_ale, mem_rd_n, mem_wr_n};
      he[2:0] = 3'h7;
      hp[2:0] = 3'h0;
    end
    @(posedge ref_clk);
    #1;
    chk({port_f_out[6], port_f_oe, port_f_pullup}, {eo, ee, ep});
    chk({port_g_out, port_g_oe, port_g_pullup}, {ho, he, hp});
    chk({port_f_input_disable, port_g_input_disable}, {fi, gi});
  endtask
  initial begin
    repeat (2000) @(posedge ref_clk);
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    acc(1'b1, 1'b0, `PAFO_DIR_A_OFS, `PAFO_DIR_A_RST);
    acc(1'b0, 1'b1, `PAFO_EXT_BASE, 8'hFF);
    acc(1'b0, 1'b0, `PAFO_SFIO_DATA_ADDR, `PAFO_SFIO_RST);
    acc(1'b1, 1'b1, `PAFO_OUT_A_OFS, 8'h5A);
    acc(1'b0, 1'b1, `PAFO_DIR_A_OFS + `PAFO_DATA_OFS, 8'h0F);
    acc(1'b1, 1'b1, 8'h5B, 8'hFF);
    acc(1'b0, 1'b0, `PAFO_OUT_A_OFS, 8'h00);
    acc(1'b0, 1'b0, `PAFO_OUT_A_OFS + `PAFO_DATA_OFS, 8'h5A);
    acc(1'b1, 1'b0, `PAFO_DIR_A_OFS, 8'h0F);
    chk({port_a_out, port_a_oe, port_a_pullup}, 24'h5A0F50);
    acc(1'b1, 1'b1, `PAFO_SFIO_OFS, 8'h04);
    acc(1'b0, 1'b0, `PAFO_SFIO_DATA_ADDR, 8'h04);
    chk(port_a_pullup, 8'h00);
    pu_off = 1'b1;
    test_port_enable <= 1'b1;
    run <= 1'b1;
    repeat (3) pins;
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(port_f_pullup, 8'hB0);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    acc(1'b1, 1'b1, `PAFO_SFIO_OFS, 8'h00);
    pu_off = 1'b0;
    {async_timer_clock_select, ext_memory_enable} <= 2'h3;
    repeat (16) pins;
    {test_port_enable, async_timer_clock_select} <= 2'h0;
    {ext_memory_enable, legacy_mode} <= 2'h1;
    repeat (3) pins;
    stop_test;
  end
endmodule // tb_port_alt_function_override
